// File: logic/sdram_dev_end.sv
`timescale 1ns/1ps
// ==========================================================
// Memory end: decodes address, bank and masks per command
module sdram_dev_end
(
	input wire logic sys_clk,
	input wire logic arst_n,
	sdram_if.dev bus,
	input wire logic [sdram_pkg::BURST_W-1:0] burst_length,
	input wire logic [sdram_pkg::DATA_W-1:0] rd_data,
	input wire logic rd_valid,
	output logic row_open,
	output logic [sdram_pkg::BANK_W-1:0] row_bank,
	output logic [sdram_pkg::ADDR_W-1:0] row_addr,
	output logic [sdram_pkg::NUM_BANKS-1:0] bank_precharge,
	output logic mode_load,
	output logic [sdram_pkg::OPCODE_W-1:0] mode_opcode,
	output logic beat_valid,
	output logic beat_write,
	output logic [sdram_pkg::BANK_W-1:0] beat_bank,
	output logic [sdram_pkg::COL_W-1:0] beat_col,
	output logic [sdram_pkg::DATA_W-1:0] beat_wr_data,
	output logic [sdram_pkg::LANES-1:0] beat_byte_we
);
	// ==========================================================
	// Pin decode, all combinational ahead of the sampling edge
	logic [3:0] cmd;
	logic selected;
	logic [sdram_pkg::BANK_W-1:0] bank;
	logic [sdram_pkg::LANES-1:0] mask;
	logic is_access;

	assign cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
	assign selected = !bus.cs_n;
	assign bank = {bus.bank_select_msb, bus.bank_select_lsb};
	// Lane 0 follows the low mask, lane 1 the high mask
	assign mask = {bus.byte_mask_high, bus.byte_mask_low};
	assign is_access = selected &&
		(cmd == sdram_pkg::CMD_READ || cmd == sdram_pkg::CMD_WRITE);

	// ==========================================================
	// Command outputs
	logic row_open_reg, row_open_next;
	logic [sdram_pkg::BANK_W-1:0] row_bank_reg, row_bank_next;
	logic [sdram_pkg::ADDR_W-1:0] row_addr_reg, row_addr_next;
	logic [sdram_pkg::NUM_BANKS-1:0] precharge_reg, precharge_next;
	logic mode_load_reg, mode_load_next;
	logic [sdram_pkg::OPCODE_W-1:0] opcode_reg, opcode_next;

	// ==========================================================
	// Burst state
	logic [sdram_pkg::BURST_W-1:0] left_reg, left_next;
	logic [sdram_pkg::BANK_W-1:0] b_bank_reg, b_bank_next;
	logic [sdram_pkg::COL_W-1:0] b_col_reg, b_col_next;
	logic b_write_reg, b_write_next;
	logic b_ap_reg, b_ap_next;
	logic beat_reg, beat_next;
	logic [sdram_pkg::DATA_W-1:0] wdata_reg, wdata_next;
	logic [sdram_pkg::LANES-1:0] we_reg, we_next;

	// ==========================================================
	// Read drive and mask pipeline
	logic [sdram_pkg::LANES-1:0] mpipe_reg [sdram_pkg::MASK_LATENCY];
	logic [sdram_pkg::LANES-1:0] mpipe_next [sdram_pkg::MASK_LATENCY];
	logic [sdram_pkg::DATA_W-1:0] dout_reg, dout_next;
	logic [sdram_pkg::LANES-1:0] doe_reg, doe_next;

	// Commands are decoded only while selected
	always_comb
	begin
		row_open_next = selected && cmd == sdram_pkg::CMD_ACTIVE;
		row_bank_next = row_bank_reg;
		row_addr_next = row_addr_reg;
		if (row_open_next)
		begin
			row_bank_next = bank;
			row_addr_next = bus.address_lines;
		end
		mode_load_next = selected && cmd == sdram_pkg::CMD_LOAD_MODE;
		opcode_next = opcode_reg;
		if (mode_load_next)
			opcode_next = {bank, bus.address_lines};
	end

	// Burst counter, stepped by every edge whether selected or not
	always_comb
	begin
		left_next = left_reg;
		b_bank_next = b_bank_reg;
		b_col_next = b_col_reg;
		b_write_next = b_write_reg;
		b_ap_next = b_ap_reg;
		beat_next = 1'b0;
		if (is_access)
		begin
			// A new access cuts off any running burst
			beat_next = 1'b1;
			b_bank_next = bank;
			b_col_next = bus.address_lines[sdram_pkg::COL_W-1:0];
			// Bits 9 and 11 play no part in an access
			b_ap_next = bus.address_lines[sdram_pkg::PRECHARGE_BIT];
			b_write_next = cmd == sdram_pkg::CMD_WRITE;
			left_next = (burst_length == 4'h0) ? 4'h0 :
				burst_length - 4'h1;
		end
		else if (left_reg != 4'h0)
		begin
			beat_next = 1'b1;
			b_col_next = b_col_reg + 9'h001;
			left_next = left_reg - 4'h1;
		end
	end

	// Precharge: explicit command, or auto after the last beat
	always_comb
	begin
		precharge_next = 4'h0;
		if (selected && cmd == sdram_pkg::CMD_PRECHARGE)
		begin
			if (bus.address_lines[sdram_pkg::PRECHARGE_BIT])
				precharge_next = 4'hF;
			else
				precharge_next[bank] = 1'b1;
		end
		if (beat_reg && !beat_next && b_ap_reg)
			precharge_next[b_bank_reg] = 1'b1;
	end

	// Write beat: masked bytes are not handed to the array
	always_comb
	begin
		wdata_next = bus.data_lines;
		we_next = 2'h0;
		if (beat_next && b_write_next)
			we_next = ~mask;
	end

	// Masks keep working regardless of chip select
	always_comb
	begin
		mpipe_next[0] = mask;
		for (int i = 1; i < sdram_pkg::MASK_LATENCY; i++)
			mpipe_next[i] = mpipe_reg[i-1];
		dout_next = rd_data;
		doe_next = 2'h0;
		for (int l = 0; l < sdram_pkg::LANES; l++)
			// Lane floats two edges after its mask is seen
			doe_next[l] = rd_valid &&
				!mpipe_reg[sdram_pkg::MASK_LATENCY-1][l];
	end

	// Every input but arst_n acts only at the rising edge
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			row_open_reg <= 1'b0;
			row_bank_reg <= sdram_pkg::BANK_RESET;
			row_addr_reg <= sdram_pkg::ADDR_RESET;
			precharge_reg <= 4'h0;
			mode_load_reg <= 1'b0;
			opcode_reg <= sdram_pkg::OPCODE_RESET;
			left_reg <= sdram_pkg::BURST_RESET;
			b_bank_reg <= sdram_pkg::BANK_RESET;
			b_col_reg <= 9'h000;
			b_write_reg <= 1'b0;
			b_ap_reg <= 1'b0;
			beat_reg <= 1'b0;
			wdata_reg <= sdram_pkg::DATA_RESET;
			we_reg <= 2'h0;
			for (int i = 0; i < sdram_pkg::MASK_LATENCY; i++)
				mpipe_reg[i] <= sdram_pkg::MASK_RESET;
			dout_reg <= sdram_pkg::DATA_RESET;
			doe_reg <= 2'h0;
		end
		else
		begin
			row_open_reg <= row_open_next;
			row_bank_reg <= row_bank_next;
			row_addr_reg <= row_addr_next;
			precharge_reg <= precharge_next;
			mode_load_reg <= mode_load_next;
			opcode_reg <= opcode_next;
			left_reg <= left_next;
			b_bank_reg <= b_bank_next;
			b_col_reg <= b_col_next;
			b_write_reg <= b_write_next;
			b_ap_reg <= b_ap_next;
			beat_reg <= beat_next;
			wdata_reg <= wdata_next;
			we_reg <= we_next;
			mpipe_reg <= mpipe_next;
			dout_reg <= dout_next;
			doe_reg <= doe_next;
		end
	end

	// ==========================================================
	// Outputs, all straight from flops
	assign row_open = row_open_reg;
	assign row_bank = row_bank_reg;
	assign row_addr = row_addr_reg;
	assign bank_precharge = precharge_reg;
	assign mode_load = mode_load_reg;
	assign mode_opcode = opcode_reg;
	assign beat_valid = beat_reg;
	assign beat_write = b_write_reg;
	assign beat_bank = b_bank_reg;
	assign beat_col = b_col_reg;
	assign beat_wr_data = wdata_reg;
	assign beat_byte_we = we_reg;
	assign bus.dev_data_out = dout_reg;
	assign bus.dev_data_oe = doe_reg;
endmodule

// File: logic/sdram_host_end.sv
`timescale 1ns/1ps
// ==========================================================
// Controller end: turns requests into registered pin states
module sdram_host_end
(
	input wire logic sys_clk,
	input wire logic arst_n,
	sdram_if.host bus,
	input wire logic req_valid,
	input wire sdram_pkg::host_req_t req_cmd,
	input wire logic [sdram_pkg::BANK_W-1:0] req_bank,
	input wire logic [sdram_pkg::ADDR_W-1:0] req_addr,
	input wire logic req_precharge_flag,
	input wire logic [sdram_pkg::OPCODE_W-1:0] req_opcode,
	input wire logic [sdram_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_drive,
	input wire logic [sdram_pkg::LANES-1:0] byte_mask,
	output logic [sdram_pkg::DATA_W-1:0] rd_data
);
	// ==========================================================
	// Pin registers
	logic [3:0] cmd_reg, cmd_next;
	logic [sdram_pkg::BANK_W-1:0] bank_reg, bank_next;
	logic [sdram_pkg::ADDR_W-1:0] addr_reg, addr_next;
	logic [sdram_pkg::LANES-1:0] mask_reg, mask_next;
	logic [sdram_pkg::DATA_W-1:0] wdata_reg, wdata_next;
	logic drive_reg, drive_next;
	logic [sdram_pkg::DATA_W-1:0] rdata_reg, rdata_next;

	// Idle cycles deselect, so the memory ignores the command, bank and address lines
	always_comb
	begin
		cmd_next = sdram_pkg::CMD_DESELECT;
		bank_next = bank_reg;
		addr_next = addr_reg;
		if (req_valid)
		begin
			unique case (req_cmd)
				sdram_pkg::REQ_NOP:
					cmd_next = sdram_pkg::CMD_NOP;
				sdram_pkg::REQ_ACTIVE:
				begin
					cmd_next = sdram_pkg::CMD_ACTIVE;
					bank_next = req_bank;
					addr_next = req_addr;
				end
				sdram_pkg::REQ_READ, sdram_pkg::REQ_WRITE:
				begin
					cmd_next = (req_cmd == sdram_pkg::REQ_READ) ?
						sdram_pkg::CMD_READ : sdram_pkg::CMD_WRITE;
					bank_next = req_bank;
					// Column plus auto precharge flag on line 10; lines 11 and 9 held low
					addr_next = {1'b0, req_precharge_flag, 1'b0,
						req_addr[sdram_pkg::COL_W-1:0]};
				end
				sdram_pkg::REQ_PRECHARGE:
				begin
					cmd_next = sdram_pkg::CMD_PRECHARGE;
					bank_next = req_bank;
					addr_next = {1'b0, req_precharge_flag, 10'h000};
				end
				sdram_pkg::REQ_LOAD_MODE:
				begin
					cmd_next = sdram_pkg::CMD_LOAD_MODE;
					{bank_next, addr_next} = req_opcode;
				end
				default:
					cmd_next = sdram_pkg::CMD_DESELECT;
			endcase
		end
	end

	// Masks and write data pass every cycle, selected or not
	always_comb
	begin
		mask_next = byte_mask;
		wdata_next = wr_data;
		drive_next = wr_drive;
		rdata_next = bus.data_lines;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cmd_reg <= sdram_pkg::CMD_DESELECT;
			bank_reg <= sdram_pkg::BANK_RESET;
			addr_reg <= sdram_pkg::ADDR_RESET;
			mask_reg <= sdram_pkg::MASK_RESET;
			wdata_reg <= sdram_pkg::DATA_RESET;
			drive_reg <= 1'b0;
			rdata_reg <= sdram_pkg::DATA_RESET;
		end
		else
		begin
			cmd_reg <= cmd_next;
			bank_reg <= bank_next;
			addr_reg <= addr_next;
			mask_reg <= mask_next;
			wdata_reg <= wdata_next;
			drive_reg <= drive_next;
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================================
	// Outputs, all straight from flops
	assign bus.cs_n = cmd_reg[3];
	assign bus.ras_n = cmd_reg[2];
	assign bus.cas_n = cmd_reg[1];
	assign bus.we_n = cmd_reg[0];
	assign bus.bank_select_lsb = bank_reg[0];
	assign bus.bank_select_msb = bank_reg[1];
	assign bus.address_lines = addr_reg;
	assign bus.byte_mask_low = mask_reg[0];
	assign bus.byte_mask_high = mask_reg[1];
	assign bus.host_data_out = wdata_reg;
	assign bus.host_data_oe = drive_reg;
	assign rd_data = rdata_reg;
endmodule

// File: logic/sdram_if.sv
`timescale 1ns/1ps
// ==========================================================
// Pins between controller and memory
interface sdram_if;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic bank_select_lsb;
	logic bank_select_msb;
	logic [sdram_pkg::ADDR_W-1:0] address_lines;
	logic byte_mask_low;
	logic byte_mask_high;
	logic [sdram_pkg::DATA_W-1:0] host_data_out;
	logic host_data_oe;
	logic [sdram_pkg::DATA_W-1:0] dev_data_out;
	logic [sdram_pkg::LANES-1:0] dev_data_oe;
	logic [sdram_pkg::DATA_W-1:0] data_lines;

	// Wire level per lane; an undriven lane reads as zero here
	assign data_lines[7:0] = dev_data_oe[0] ? dev_data_out[7:0] :
		(host_data_oe ? host_data_out[7:0] : 8'h00);
	assign data_lines[15:8] = dev_data_oe[1] ? dev_data_out[15:8] :
		(host_data_oe ? host_data_out[15:8] : 8'h00);

	modport host
	(
		output cs_n, ras_n, cas_n, we_n,
		output bank_select_lsb, bank_select_msb, address_lines,
		output byte_mask_low, byte_mask_high,
		output host_data_out, host_data_oe,
		input data_lines
	);
	modport dev
	(
		input cs_n, ras_n, cas_n, we_n,
		input bank_select_lsb, bank_select_msb, address_lines,
		input byte_mask_low, byte_mask_high,
		output dev_data_out, dev_data_oe,
		input data_lines
	);
endinterface

// File: logic/sdram_pkg.sv
// Functional notes
// - High write mask blocks that byte's write
// - High read mask floats lane two clocks later
// - Low mask: bits 0-7; high mask: 8-15
// - Generic mask means both masks alike
// - Bank select names the command's target bank
// - ACTIVE captures all twelve lines as row
// - READ/WRITE column from nine lowest lines
// - Bit ten on access selects auto precharge
// - Bit ten on precharge: all banks, else one
// - Mode load op-code from bank and address
// - Everything sampled on rising edge; bursts step
// - Deselected: commands ignored, bursts and masks continue
package sdram_pkg;
	// ==========================================================
	// Widths
	localparam int ADDR_W = 12;
	localparam int COL_W = 9;
	localparam int BANK_W = 2;
	localparam int NUM_BANKS = 4;
	localparam int LANES = 2;
	localparam int LANE_W = 8;
	localparam int DATA_W = 16;
	localparam int OPCODE_W = 14;
	localparam int BURST_W = 4;
	localparam int PRECHARGE_BIT = 10;

	// ==========================================================
	// Timing
	localparam int MASK_LATENCY = 2;

	// ==========================================================
	// Pin command codes as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_ACTIVE = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DESELECT = 4'hF;

	// ==========================================================
	// Reset values
	localparam logic [BANK_W-1:0] BANK_RESET = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [LANES-1:0] MASK_RESET = 2'h3;
	localparam logic [BURST_W-1:0] BURST_RESET = 4'h0;
	localparam logic [OPCODE_W-1:0] OPCODE_RESET = 14'h0000;

	// Requests taken by the controller end
	typedef enum logic [2:0]
	{
		REQ_NOP,
		REQ_ACTIVE,
		REQ_READ,
		REQ_WRITE,
		REQ_PRECHARGE,
		REQ_LOAD_MODE
	} host_req_t;
endpackage

// File: verif/sdram_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// Pin checks between the controller end and the memory end
module sdram_asserts
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic bank_select_lsb,
	input wire logic bank_select_msb,
	input wire logic [sdram_pkg::ADDR_W-1:0] address_lines,
	input wire logic byte_mask_low,
	input wire logic byte_mask_high,
	input wire logic [sdram_pkg::LANES-1:0] dev_data_oe
);
	logic [3:0] cmd;

	// Command code as seen on the pins
	assign cmd = {cs_n, ras_n, cas_n, we_n};

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// ==========================================================
	// Mask pipe: one edge on the pins, then two edges of latency
	a_low_lane_float: assert property (
		byte_mask_low |-> ##3 !dev_data_oe[0])
		else $error("low lane driven under mask");
	a_high_lane_float: assert property (
		byte_mask_high |-> ##3 !dev_data_oe[1])
		else $error("high lane driven under mask");
	a_both_lanes_float: assert property (
		byte_mask_low && byte_mask_high |-> ##3 dev_data_oe == 2'h0)
		else $error("lanes driven under full mask");
	a_mask_when_idle: assert property (
		cs_n && byte_mask_high |-> ##3 !dev_data_oe[1])
		else $error("mask lost while deselected");
	a_drive_unmasked: assert property (
		dev_data_oe[1] |-> $past(!byte_mask_high, 3))
		else $error("high lane driven without clear mask");

	// ==========================================================
	// Address and bank shape per command
	a_bank_addr_hold: assert property (
		cs_n |-> $stable({bank_select_msb, bank_select_lsb, address_lines}))
		else $error("bank or address moved without command");
	a_pre_addr_shape: assert property (
		cmd == sdram_pkg::CMD_PRECHARGE
		|-> address_lines[9:0] == 10'h000 && !address_lines[11])
		else $error("precharge address not clean");
	a_rw_addr_shape: assert property (
		cmd == sdram_pkg::CMD_READ || cmd == sdram_pkg::CMD_WRITE
		|-> !address_lines[11] && !address_lines[9])
		else $error("access address above column field");

	// Main scenarios reached
	c_write: cover property (cmd == sdram_pkg::CMD_WRITE);
	c_pre_all: cover property (cmd == sdram_pkg::CMD_PRECHARGE
		&& address_lines[10]);
	c_float: cover property (byte_mask_low ##3 dev_data_oe == 2'h2);
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Both ends face each other; bench drives their user sides
module tb_top;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic req_valid = 1'b0;
	sdram_pkg::host_req_t req_cmd = sdram_pkg::REQ_NOP;
	logic [1:0] req_bank = 2'h0;
	logic [11:0] req_addr = 12'h000;
	logic req_flag = 1'b0;
	logic [13:0] req_opcode = 14'h0000;
	logic [15:0] wr_data = 16'h0000;
	logic wr_drive = 1'b0;
	logic [1:0] byte_mask = 2'h0;
	logic [3:0] burst_length = 4'h1;
	logic [15:0] dev_rd_data = 16'h0000;
	logic rd_valid = 1'b0;
	logic [15:0] host_rd, beat_wr_data;
	logic row_open, mode_load, beat_valid, beat_write;
	logic [1:0] row_bank, beat_bank, beat_byte_we;
	logic [11:0] row_addr;
	logic [3:0] bank_precharge;
	logic [13:0] mode_opcode;
	logic [8:0] beat_col;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;

	always #2 sys_clk = ~sys_clk;

	sdram_if bus_if();
	sdram_host_end u_sdram_host_end(.sys_clk(sys_clk), .arst_n(arst_n),
		.bus(bus_if), .req_valid(req_valid), .req_cmd(req_cmd),
		.req_bank(req_bank), .req_addr(req_addr),
		.req_precharge_flag(req_flag), .req_opcode(req_opcode),
		.wr_data(wr_data), .wr_drive(wr_drive), .byte_mask(byte_mask),
		.rd_data(host_rd));
	sdram_dev_end u_sdram_dev_end(.sys_clk(sys_clk), .arst_n(arst_n),
		.bus(bus_if), .burst_length(burst_length), .rd_data(dev_rd_data),
		.rd_valid(rd_valid), .row_open(row_open), .row_bank(row_bank),
		.row_addr(row_addr), .bank_precharge(bank_precharge),
		.mode_load(mode_load), .mode_opcode(mode_opcode),
		.beat_valid(beat_valid), .beat_write(beat_write),
		.beat_bank(beat_bank), .beat_col(beat_col),
		.beat_wr_data(beat_wr_data), .beat_byte_we(beat_byte_we));
	sdram_asserts u_sdram_asserts(.sys_clk(sys_clk), .arst_n(arst_n),
		.cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n),
		.we_n(bus_if.we_n), .bank_select_lsb(bus_if.bank_select_lsb),
		.bank_select_msb(bus_if.bank_select_msb),
		.address_lines(bus_if.address_lines),
		.byte_mask_low(bus_if.byte_mask_low),
		.byte_mask_high(bus_if.byte_mask_high),
		.dev_data_oe(bus_if.dev_data_oe));

	// ==========================================================
	// Shared helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// Let the next edge's updates land before looking
	task automatic nxt;
		@(posedge sys_clk);
		#1;
	endtask

	// One request for one cycle; opcode mirrors bank and address
	task automatic issue(input sdram_pkg::host_req_t c,
		input logic [1:0] b, input logic [11:0] a, input logic f);
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_cmd <= c;
		req_bank <= b;
		req_addr <= a;
		req_flag <= f;
		req_opcode <= {b, a};
		@(posedge sys_clk);
		req_valid <= 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic s_active_mode;
		issue(sdram_pkg::REQ_ACTIVE, 2'h2, 12'hABC, 1'b0);
		nxt;
		chk(row_open, 1'b1);
		chk(row_bank, 2'h2);
		chk(row_addr, 12'hABC);
		issue(sdram_pkg::REQ_LOAD_MODE, 2'h2, 12'hA5C, 1'b0);
		nxt;
		chk(mode_load, 1'b1);
		chk(mode_opcode, 14'h2A5C);
		// A selected no-op must leave every captured value alone
		issue(sdram_pkg::REQ_NOP, 2'h0, 12'h000, 1'b0);
		nxt;
		chk({row_open, mode_load, beat_valid, bank_precharge}, 7'h00);
		chk(row_addr, 12'hABC);
		chk(mode_opcode, 14'h2A5C);
	endtask

	task automatic s_precharge;
		for (int b = 0; b < 4; b++)
		begin
			issue(sdram_pkg::REQ_PRECHARGE, 2'(b), 12'h000, 1'b0);
			nxt;
			chk(bank_precharge, 4'h1 << b);
		end
		issue(sdram_pkg::REQ_PRECHARGE, 2'h1, 12'h000, 1'b1);
		nxt;
		chk(bank_precharge, 4'hF);
	endtask

	// Masked first beat, open second, then auto precharge of bank 1
	task automatic s_write;
		@(posedge sys_clk);
		burst_length <= 4'h2;
		wr_drive <= 1'b1;
		byte_mask <= 2'h1;
		wr_data <= 16'h1234;
		issue(sdram_pkg::REQ_WRITE, 2'h1, 12'h005, 1'b1);
		byte_mask <= 2'h0;
		wr_data <= 16'h5678;
		nxt;
		chk({beat_valid, beat_write, beat_bank}, 4'hD);
		chk(beat_col, 9'h005);
		chk(beat_wr_data, 16'h1234);
		chk(beat_byte_we, 2'h2);
		nxt;
		chk(beat_col, 9'h006);
		chk(beat_wr_data, 16'h5678);
		chk(beat_byte_we, 2'h3);
		nxt;
		chk(beat_valid, 1'b0);
		chk(bank_precharge, 4'h2);
		@(posedge sys_clk);
		wr_drive <= 1'b0;
	endtask

	// Burst runs on while deselected and wraps the column
	task automatic s_read;
		issue(sdram_pkg::REQ_READ, 2'h3, 12'h1FF, 1'b0);
		nxt;
		chk({beat_write, beat_bank}, 3'h3);
		chk(beat_col, 9'h1FF);
		nxt;
		chk({beat_valid, beat_col}, 10'h200);
		nxt;
		chk({row_open, bank_precharge}, 5'h00);
	endtask

	// A one-cycle mask floats its lanes for one cycle only
	task automatic s_float(input logic [1:0] m);
		@(posedge sys_clk);
		rd_valid <= 1'b1;
		dev_rd_data <= 16'hA55A;
		@(posedge sys_clk);
		byte_mask <= m;
		@(posedge sys_clk);
		byte_mask <= 2'h0;
		repeat (2) nxt;
		chk(bus_if.dev_data_oe, 2'h3);
		nxt;
		// XOR keeps the inversion to two bits in the wide compare
		chk(bus_if.dev_data_oe, m ^ 2'h3);
		nxt;
		chk(host_rd, {m[1] ? 8'h00 : 8'hA5, m[0] ? 8'h00 : 8'h5A});
		chk(bus_if.dev_data_oe, 2'h3);
	endtask

	// ==========================================================
	// Verdict and hang guard
	task automatic tally_and_finish;
		$display("errors %0d of %0d checks", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial
	begin
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		s_active_mode();
		s_precharge();
		s_write();
		s_read();
		for (int i = 1; i < 4; i++)
			s_float(2'(i));
		tally_and_finish();
	end
endmodule
